// ### rtl/cgr_pkg.sv
// shared constants for the calibration and port register bank link
//
// Functional notes
// - byte 0Ch: offset trim high, resets 00h
// - byte 0Bh: offset trim low, resets 00h
// - slot 0Dh reads zero; host writes zero
// - byte 0Eh: gain trim low, resets 00h
// - byte 0Fh: gain trim high, resets 40h
// - 10h bits 7:4: zero output, one input
// - 10h bits 3:0: pin levels, reset zero
// - 11h bits 3:0 select each pin's function
// - function zero analog, one digital port
// - 11h bits 7:4 read zero; host writes zero
// - six-input variant: pins disabled until enabled
// - serial clock rests low, mode one
// - drive data only on rising edges
// - sample data only on falling edges
package cgr_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS   = 4;   // pclk period
  localparam int HALF_NS  = 48;  // least serial clock half period, host
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------------
  // serial frame: read flag, 7-bit offset, 8-bit data, msb first
  // ------------------------------------------------------------------
  localparam int FRAME_BITS       = 16;
  localparam int RD_BIT           = 15;
  localparam int ADR_LSB          = 8;
  localparam logic [4:0] ADR_DONE = 5'h07;
  localparam logic [4:0] LAST_BIT = 5'h0F;

  // ------------------------------------------------------------------
  // device register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] ADR_OFS_LO  = 7'h0B;
  localparam logic [6:0] ADR_OFS_HI  = 7'h0C;
  localparam logic [6:0] ADR_RSVD    = 7'h0D;
  localparam logic [6:0] ADR_GAIN_LO = 7'h0E;
  localparam logic [6:0] ADR_GAIN_HI = 7'h0F;
  localparam logic [6:0] ADR_PORT    = 7'h10;
  localparam logic [6:0] ADR_FUNC    = 7'h11;
  localparam logic [7:0] RST_OFS_LO  = 8'h00;
  localparam logic [7:0] RST_OFS_HI  = 8'h00;
  localparam logic [7:0] RST_GAIN_LO = 8'h00;
  localparam logic [7:0] RST_GAIN_HI = 8'h40;
  localparam logic [7:0] RST_PORT    = 8'h00;
  localparam logic [7:0] RST_FUNC    = 8'h00;
  localparam int DIR_LSB             = 4;
  localparam int LVL_LSB             = 0;
  localparam logic [7:0] FUNC_MASK   = 8'h0F;

  // ------------------------------------------------------------------
  // host apb map
  // ------------------------------------------------------------------
  localparam logic [11:0] A_CMD          = 12'h000;
  localparam logic [11:0] A_STAT         = 12'h004;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_RDATA_LSB = 8;

endpackage : cgr_pkg

// ### rtl/cgr_spi_if.sv
// serial link between host controller and register bank
`timescale 1ns/100ps
`default_nettype none
interface cgr_spi_if;
  logic sclk;     // rests low between frames
  logic cs_n;     // frame select, active low
  logic mosi;     // host to device
  logic miso;     // device to host
  logic miso_oe;  // device drives miso while high

  modport dev (
    input  sclk,
    input  cs_n,
    input  mosi,
    output miso,
    output miso_oe
  );
  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input  miso
  );
endinterface : cgr_spi_if
`default_nettype wire

// ### rtl/cgr_dev.sv
// register bank end: serial slave, trim words and port pins
`timescale 1ns/100ps
`default_nettype none
module cgr_dev #(
  parameter int GPIO_PINS = 4,
  parameter bit SIX_INPUT = 1'b0
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  cgr_spi_if.dev                    spi,
  output logic [15:0]               offset_trim_word,
  output logic [15:0]               gain_trim_word,
  input  wire logic [GPIO_PINS-1:0] gpio_in,
  output logic [GPIO_PINS-1:0]      gpio_out,
  output logic [GPIO_PINS-1:0]      gpio_oe,
  output logic [GPIO_PINS-1:0]      analog_en
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  // the port byte packs four orientation and four level bits
  if (GPIO_PINS != 4) begin : g_bad_pins
    $error("cgr_dev: GPIO_PINS must be 4");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       sclk_m;
    logic       sclk_s;
    logic       sclk_d;
    logic       cs_m;
    logic       cs_s;
    logic       mosi_m;
    logic       mosi_s;
    logic [3:0] gpio_m;
    logic [3:0] gpio_s;
    logic [4:0] cnt;
    logic [7:0] rx;
    logic [6:0] adr;
    logic       rd;
    logic [7:0] tx;
    logic       miso;
    logic       miso_oe;
    logic [7:0] ofs_lo;
    logic [7:0] ofs_hi;
    logic [7:0] gain_lo;
    logic [7:0] gain_hi;
    logic [7:0] port;
    logic [7:0] func;
  } cgr_dev_st_t;

  localparam cgr_dev_st_t DEV_RST = '{
    cs_m:    1'b1,
    cs_s:    1'b1,
    ofs_lo:  cgr_pkg::RST_OFS_LO,
    ofs_hi:  cgr_pkg::RST_OFS_HI,
    gain_lo: cgr_pkg::RST_GAIN_LO,
    gain_hi: cgr_pkg::RST_GAIN_HI,
    port:    cgr_pkg::RST_PORT,
    func:    cgr_pkg::RST_FUNC,
    default: '0
  };

  cgr_dev_st_t st_r;
  cgr_dev_st_t st_nxt;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // level bits: input pins show the sampled pad, outputs the latch
  function automatic logic [3:0] cgr_levels(
    input logic [7:0] port,
    input logic [3:0] pad
  );
    logic [3:0] dir;
    dir = port[cgr_pkg::DIR_LSB +: 4];
    cgr_levels = (dir & pad) | (~dir & port[cgr_pkg::LVL_LSB +: 4]);
  endfunction : cgr_levels

  // read decode; unmapped and reserved offsets answer zero
  function automatic logic [7:0] cgr_read(
    input logic [6:0]  adr,
    input cgr_dev_st_t s
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (adr)
      cgr_pkg::ADR_OFS_LO:  v = s.ofs_lo;
      cgr_pkg::ADR_OFS_HI:  v = s.ofs_hi;
      cgr_pkg::ADR_RSVD:    v = 8'h00;
      cgr_pkg::ADR_GAIN_LO: v = s.gain_lo;
      cgr_pkg::ADR_GAIN_HI: v = s.gain_hi;
      cgr_pkg::ADR_PORT: begin
        v = {s.port[cgr_pkg::DIR_LSB +: 4], cgr_levels(s.port, s.gpio_s)};
      end
      cgr_pkg::ADR_FUNC:    v = s.func & cgr_pkg::FUNC_MASK;
      default:              v = 8'h00;
    endcase
    cgr_read = v;
  endfunction : cgr_read

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic       rise;
  logic       fall;
  logic [7:0] byte_in;

  always_comb begin
    st_nxt = st_r;
    // two-flop synchronisers for every pin from outside pclk
    st_nxt.sclk_m = spi.sclk;
    st_nxt.sclk_s = st_r.sclk_m;
    st_nxt.sclk_d = st_r.sclk_s;
    st_nxt.cs_m   = spi.cs_n;
    st_nxt.cs_s   = st_r.cs_m;
    st_nxt.mosi_m = spi.mosi;
    st_nxt.mosi_s = st_r.mosi_m;
    st_nxt.gpio_m = gpio_in;
    st_nxt.gpio_s = st_r.gpio_m;

    // clock rests low, so a rise is always the first edge of a bit
    rise    = st_r.sclk_s & ~st_r.sclk_d;
    fall    = ~st_r.sclk_s & st_r.sclk_d;
    byte_in = {st_r.rx[6:0], st_r.mosi_s};

    st_nxt.miso_oe = ~st_r.cs_s;

    if (st_r.cs_s) begin
      // frame over: rearm, shift out zeros until an offset is known
      st_nxt.cnt = '0;
      st_nxt.tx  = 8'h00;
      st_nxt.miso = 1'b0;
    end else begin
      if (rise) begin
        st_nxt.miso = st_r.tx[7];
        st_nxt.tx   = {st_r.tx[6:0], 1'b0};
      end
      if (fall && st_r.cnt <= cgr_pkg::LAST_BIT) begin
        st_nxt.rx  = byte_in;
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == cgr_pkg::ADR_DONE) begin
          // first byte done: latch offset, preload read data
          st_nxt.rd  = byte_in[7];
          st_nxt.adr = byte_in[6:0];
          st_nxt.tx  = cgr_read(byte_in[6:0], st_r);
        end
        if (st_r.cnt == cgr_pkg::LAST_BIT && !st_r.rd) begin
          // second byte done: commit the write; extra bits are ignored
          unique case (st_r.adr)
            cgr_pkg::ADR_OFS_LO:  st_nxt.ofs_lo  = byte_in;
            cgr_pkg::ADR_OFS_HI:  st_nxt.ofs_hi  = byte_in;
            cgr_pkg::ADR_GAIN_LO: st_nxt.gain_lo = byte_in;
            cgr_pkg::ADR_GAIN_HI: st_nxt.gain_hi = byte_in;
            cgr_pkg::ADR_PORT:    st_nxt.port    = byte_in;
            cgr_pkg::ADR_FUNC: begin
              st_nxt.func = byte_in & cgr_pkg::FUNC_MASK;
            end
            default: st_nxt.func = st_r.func;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign spi.miso         = st_r.miso;
  assign spi.miso_oe      = st_r.miso_oe;
  assign offset_trim_word = {st_r.ofs_hi, st_r.ofs_lo};
  assign gain_trim_word   = {st_r.gain_hi, st_r.gain_lo};

  // a pin drives only when handed to the port and set to output;
  // a level written while it is an input waits in the latch
  assign gpio_out = st_r.port[cgr_pkg::LVL_LSB +: 4];
  assign gpio_oe  = st_r.func[3:0]
                  & ~st_r.port[cgr_pkg::DIR_LSB +: 4];

  // six-input part: cleared function bits mean pin off, not analog
  assign analog_en = SIX_INPUT ? 4'h0 : ~st_r.func[3:0];

endmodule : cgr_dev
`default_nettype wire

// ### rtl/cgr_host.sv
// host end: apb command registers driving the serial master
`timescale 1ns/100ps
`default_nettype none
module cgr_host #(
  parameter int HALF_CYC = cgr_pkg::HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  cgr_spi_if.host          spi
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  // miso needs about six pclk of round trip before the falling edge
  if (HALF_CYC < 8 || HALF_CYC > 255) begin : g_bad_half
    $error("cgr_host: HALF_CYC must be 8 to 255");
  end

  localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE,
    S_LEAD,
    S_SHIFT,
    S_TRAIL
  } cgr_hst_state_t;

  typedef struct packed {
    cgr_hst_state_t fsm;
    logic [7:0]     half;
    logic [4:0]     cnt;
    logic [15:0]    tx;
    logic [7:0]     rx;
    logic [7:0]     rdata;
    logic           sclk;
    logic           cs_n;
    logic           mosi;
    logic           miso_m;
    logic           miso_s;
    logic [31:0]    prdata;
  } cgr_hst_st_t;

  localparam cgr_hst_st_t HST_RST = '{
    fsm:     S_IDLE,
    cs_n:    1'b1,
    default: '0
  };

  cgr_hst_st_t st_r;
  cgr_hst_st_t st_nxt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic        wr_cmd;
  logic        tick;
  logic [15:0] cmd;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.miso_m = spi.miso;
    st_nxt.miso_s = st_r.miso_m;

    wr_cmd = psel & penable & pwrite & (paddr == cgr_pkg::A_CMD);
    tick   = (st_r.half == HALF_END);
    st_nxt.half = tick ? 8'h00 : st_r.half + 8'h01;

    // only zero may go to the reserved slot and function bits 7:4
    cmd = pwdata[15:0];
    if (cmd[cgr_pkg::ADR_LSB +: 7] == cgr_pkg::ADR_RSVD) begin
      cmd[7:0] = 8'h00;
    end
    if (cmd[cgr_pkg::ADR_LSB +: 7] == cgr_pkg::ADR_FUNC) begin
      cmd[7:0] = cmd[7:0] & cgr_pkg::FUNC_MASK;
    end

    // read data prepared in setup, shown in the access phase
    if (psel && !penable) begin
      unique case (paddr)
        cgr_pkg::A_STAT: begin
          st_nxt.prdata = '0;
          st_nxt.prdata[cgr_pkg::STAT_BUSY_BIT] = (st_r.fsm != S_IDLE);
          st_nxt.prdata[cgr_pkg::STAT_RDATA_LSB +: 8] = st_r.rdata;
        end
        cgr_pkg::A_CMD: st_nxt.prdata = {16'h0000, st_r.tx};
        default:        st_nxt.prdata = '0;
      endcase
    end

    unique case (st_r.fsm)
      S_IDLE: begin
        // a command written while busy is dropped
        if (wr_cmd) begin
          st_nxt.fsm  = S_LEAD;
          st_nxt.cs_n = 1'b0;
          st_nxt.tx   = cmd;
          st_nxt.cnt  = '0;
          st_nxt.half = 8'h00;
        end
      end
      S_LEAD: begin
        if (tick) begin
          st_nxt.fsm  = S_SHIFT;
          st_nxt.sclk = 1'b1;
          st_nxt.mosi = st_r.tx[cgr_pkg::RD_BIT];
          st_nxt.tx   = {st_r.tx[14:0], 1'b0};
        end
      end
      S_SHIFT: begin
        if (tick && st_r.sclk) begin
          st_nxt.sclk = 1'b0;
          st_nxt.rx   = {st_r.rx[6:0], st_r.miso_s};
          st_nxt.cnt  = st_r.cnt + 5'h01;
          if (st_r.cnt == cgr_pkg::LAST_BIT) begin
            st_nxt.fsm = S_TRAIL;
          end
        end else if (tick) begin
          st_nxt.sclk = 1'b1;
          st_nxt.mosi = st_r.tx[cgr_pkg::RD_BIT];
          st_nxt.tx   = {st_r.tx[14:0], 1'b0};
        end
      end
      S_TRAIL: begin
        // one half period with clock low, then one with select high
        if (tick && !st_r.cs_n) begin
          st_nxt.cs_n  = 1'b1;
          st_nxt.rdata = st_r.rx;
        end else if (tick) begin
          st_nxt.fsm = S_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= HST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata   = st_r.prdata;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign spi.sclk = st_r.sclk;
  assign spi.cs_n = st_r.cs_n;
  assign spi.mosi = st_r.mosi;

endmodule : cgr_host
`default_nettype wire

// ### sim/cgr_link_properties.sv
// checker for framing and edge discipline on the serial wires
`timescale 1ns/100ps
`default_nettype none
module cgr_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------
  // helper: serial clock rises seen inside the current frame
  // ------------------------------------------------------------------
  logic       sclk_d_r;
  logic [4:0] rise_cnt_r;

  // cleared while deselected so an aborted frame cannot leak counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r   <= 1'h0;
      rise_cnt_r <= 5'h00;
    end else begin
      sclk_d_r <= sclk;
      if (cs_n) begin
        rise_cnt_r <= 5'h00;
      end else if (sclk && !sclk_d_r) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_LEAD_LOW: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("serial clock rose too soon after select");
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  AST_MOSI_RISE: assert property (
    (!cs_n && sclk && $changed(mosi)) |-> $rose(sclk))
    else $error("host data moved away from a rising edge");
  AST_MOSI_FALL: assert property (
    $fell(sclk) |-> mosi == $past(mosi, 4))
    else $error("host data unsettled at falling edge");
  AST_MISO_HIGH: assert property (
    (miso_oe && $changed(miso)) |-> sclk)
    else $error("device data moved while clock low");
  AST_MISO_FALL: assert property (
    ($fell(sclk) && miso_oe) |=> $stable(miso) [*4])
    else $error("device data moved after falling edge");
  AST_SIXTEEN: assert property (
    $rose(cs_n) |-> rise_cnt_r == 5'h10)
    else $error("frame without sixteen clock periods");

  COV_FRAME: cover property ($rose(cs_n));
  COV_READ: cover property ($rose(sclk) && mosi && rise_cnt_r == 5'h00);
  COV_MISO: cover property ($fell(sclk) && miso_oe && miso);
endmodule : cgr_link_properties
`default_nettype wire

// ### sim/cal_gpio_register_bank_test.sv
// self-checking bench: host end and register bank joined by the link
`timescale 1ns/100ps
`default_nettype none
module cal_gpio_register_bank_test;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] rs;
  } cgr_row_t;

  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  gpio_in = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ofs_w;
  logic [15:0] gain_w;
  logic [3:0]  g_out;
  logic [3:0]  g_oe;
  logic [3:0]  an_en;
  logic [3:0]  an_six;
  logic [3:0]  oe_six;
  logic [15:0] mosi_sh = 16'h0000;
  logic [15:0] miso_sh = 16'h0000;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;

  // write, expected readback, reset value; 0Dh and 11h upper bits refuse
  cgr_row_t rows [7] = '{
    '{7'h0B, 8'hA5, 8'hA5, cgr_pkg::RST_OFS_LO},
    '{7'h0C, 8'h5A, 8'h5A, cgr_pkg::RST_OFS_HI},
    '{7'h0D, 8'h77, 8'h00, 8'h00},
    '{7'h0E, 8'h3C, 8'h3C, cgr_pkg::RST_GAIN_LO},
    '{7'h0F, 8'hC3, 8'hC3, cgr_pkg::RST_GAIN_HI},
    '{7'h10, 8'hA0, 8'hA0, cgr_pkg::RST_PORT},
    '{7'h11, 8'hFF, 8'h0F, cgr_pkg::RST_FUNC}};

  always #2 pclk = ~pclk;

  cgr_spi_if spi_bus ();

  cgr_host u_cgr_host (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .spi     (spi_bus)
  );

  cgr_dev u_cgr_dev (
    .pclk             (pclk),
    .presetn          (presetn),
    .spi              (spi_bus),
    .offset_trim_word (ofs_w),
    .gain_trim_word   (gain_w),
    .gpio_in          (gpio_in),
    .gpio_out         (g_out),
    .gpio_oe          (g_oe),
    .analog_en        (an_en)
  );

  // six-input part on a copy of the wires; its miso goes nowhere,
  // so it only listens and lets the pin-disable mode be checked
  cgr_spi_if six_bus ();
  assign six_bus.sclk = spi_bus.sclk;
  assign six_bus.cs_n = spi_bus.cs_n;
  assign six_bus.mosi = spi_bus.mosi;

  cgr_dev #(
    .SIX_INPUT (1'b1)
  ) u_cgr_dev_six (
    .pclk             (pclk),
    .presetn          (presetn),
    .spi              (six_bus),
    .offset_trim_word (),
    .gain_trim_word   (),
    .gpio_in          (gpio_in),
    .gpio_out         (),
    .gpio_oe          (oe_six),
    .analog_en        (an_six)
  );

  cgr_link_properties u_props (
    .pclk    (pclk),
    .presetn (presetn),
    .sclk    (spi_bus.sclk),
    .cs_n    (spi_bus.cs_n),
    .mosi    (spi_bus.mosi),
    .miso    (spi_bus.miso),
    .miso_oe (spi_bus.miso_oe)
  );

  // ------------------------------------------------------------------
  // wire capture and hang guard
  // ------------------------------------------------------------------
  // both sides are settled at the falling edge, so sample there
  always @(negedge spi_bus.sclk) begin
    mosi_sh <= {mosi_sh[14:0], spi_bus.mosi};
    miso_sh <= {miso_sh[14:0], spi_bus.miso};
  end

  // about thirty frames of some 450 cycles each fit well below this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    r = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // one serial frame, then poll busy; read data lands in q[15:8]
  task automatic frame(input logic rd, input logic [6:0] a,
                       input logic [7:0] d);
    logic [7:0] dd;
    dd = (a == cgr_pkg::ADR_RSVD) ? 8'h00 : d;
    if (a == cgr_pkg::ADR_FUNC) begin
      dd = d & cgr_pkg::FUNC_MASK;
    end
    apb(1'h1, cgr_pkg::A_CMD, {16'h0000, rd, a, d}, q);
    q = 32'h0000_0001;
    while (q[cgr_pkg::STAT_BUSY_BIT] !== 1'h0) begin
      apb(1'h0, cgr_pkg::A_STAT, 32'h0000_0000, q);
    end
    chk("mosi frame", {rd, a, dd}, mosi_sh);
    chk("idle wires", 16'h0002, {14'h0000, spi_bus.cs_n, spi_bus.sclk});
  endtask : frame

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    // ordinary cases: write a byte, read it back over the wire
    foreach (rows[i]) begin
      frame(1'h0, rows[i].a, rows[i].wd);
      frame(1'h1, rows[i].a, 8'h00);
      chk("readback", {8'h00, rows[i].rd},
          {8'h00, q[15:8]});
      chk("miso byte", {8'h00, rows[i].rd}, {8'h00, miso_sh[7:0]});
    end
    chk("offset word", 16'h5AA5, ofs_w);
    chk("gain word", 16'hC33C, gain_w);
    chk("analog enable", 16'h0000, {12'h000, an_en});
    chk("pin enable", 16'h0005, {12'h000, g_oe});
    // six-input part: never analog, pins live once function bits set
    chk("six pin enable", 16'h0005, {12'h000, oe_six});
    chk("six analog enable", 16'h0000, {12'h000, an_six});
    // mixed directions: inputs read the pad, outputs the latch
    gpio_in <= 4'h5;
    frame(1'h0, cgr_pkg::ADR_PORT, 8'h5A);
    chk("pin enable", 16'h000A, {12'h000, g_oe});
    chk("pin level", 16'h000A, {12'h000, g_out});
    frame(1'h1, cgr_pkg::ADR_PORT, 8'h00);
    chk("port read", 16'h005F, {8'h00, q[15:8]});
    gpio_in <= 4'h0;
    frame(1'h1, cgr_pkg::ADR_PORT, 8'h00);
    chk("port read", 16'h005A, {8'h00, q[15:8]});
    // latched level must stay off the pins until they turn to outputs
    frame(1'h0, cgr_pkg::ADR_PORT, 8'hF3);
    chk("pin enable", 16'h0000, {12'h000, g_oe});
    chk("pin level", 16'h0003, {12'h000, g_out});
    frame(1'h0, cgr_pkg::ADR_PORT, 8'h03);
    chk("pin enable", 16'h000F, {12'h000, g_oe});
    frame(1'h0, cgr_pkg::ADR_FUNC, 8'h00);
    chk("pin enable", 16'h0000, {12'h000, g_oe});
    chk("analog enable", 16'h000F, {12'h000, an_en});
    // unmapped apb word: write ignored, reads zero
    apb(1'h1, 12'h008, 32'hFFFF_FFFF, q);
    apb(1'h0, 12'h008, 32'h0000_0000, q);
    chk("unmapped read", 16'h0000, q[15:0]);
    chk("slave error", 16'h0000, {15'h0000, pslverr});
    // second reset mid-run restores every byte
    presetn <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("offset word", 16'h0000, ofs_w);
    chk("gain word", 16'h4000, gain_w);
    chk("pin enable", 16'h0000, {12'h000, g_oe});
    chk("analog enable", 16'h000F, {12'h000, an_en});
    chk("six pin enable", 16'h0000, {12'h000, oe_six});
    chk("six analog enable", 16'h0000, {12'h000, an_six});
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    foreach (rows[i]) begin
      frame(1'h1, rows[i].a, 8'h00);
      chk("reset value", {8'h00, rows[i].rs},
          {8'h00, q[15:8]});
    end
    complete_run();
  end
endmodule : cal_gpio_register_bank_test
`default_nettype wire
